// >>> bench/ebhh_master_model.sv
// Outside bus master that borrows the memory bus.
`timescale 1ns/1ns
module ebhh_master_model #(
  parameter int KEEP = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bench control
  input wire logic go_i,
  // Handshake pins
  input wire logic ext_bus_grant_n_i,
  output logic ext_bus_req_n_o
);
  int cnt_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ext_bus_req_n_o <= 1'b1;
      cnt_q <= 0;
    end else if (ext_bus_grant_n_i) begin
      ext_bus_req_n_o <= !go_i;
      cnt_q <= 0;
    end else begin
      // Request stays low longer than the slowest interface period.
      cnt_q <= cnt_q + 1;
      if (cnt_q >= KEEP) ext_bus_req_n_o <= 1'b1;
    end
  end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the external bus hold handshake.
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ext_clk = 1'b0;
  logic [1:0] sel = 2'h1;
  logic refuse = 1'b0;
  logic fsel = 1'b0;
  logic pend = 1'b0;
  logic go = 1'b0;
  logic req_n, grant_n, bus_oe, mclk, mclk_oe, clkz;
  ebhh_pkg::ebhh_bus_t bus_v = '1;
  ebhh_pkg::ebhh_bus_t bus_q;
  int mismatches = 0;
  int check_count = 0;
  int t[6];
  int tog, skew;
  always #20 clk_i = ~clk_i;
  initial begin
    #5;
    forever #200 ext_clk = ~ext_clk;
  end
  ebhh_hold i_ebhh_hold (.clk_i(clk_i), .nrst_i(nrst_i), .clk_sel_i(sel), .mem_clock_in_i(ext_clk),
    .bus_release_refuse_i(refuse), .memclk_float_sel_i(fsel), .xfer_pending_i(pend), .bus_i(bus_v),
    .ext_bus_req_n_i(req_n), .ext_bus_grant_n_o(grant_n), .bus_o(bus_q), .bus_oe_o(bus_oe),
    .mem_clock_out_o(mclk), .mem_clock_out_oe_o(mclk_oe), .hold_active_o());
  ebhh_master_model i_ebhh_master_model (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go),
    .ext_bus_grant_n_i(grant_n), .ext_bus_req_n_o(req_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Records the cycle of each handshake edge over one full hold.
  task automatic hold_cycle(input logic f, input logic p);
    logic last;
    tog = 0;
    skew = 0;
    clkz = 1'b0;
    last = mclk;
    foreach (t[k]) t[k] = -1;
    fsel <= f;
    pend <= p;
    go <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      if (i == 40) pend <= 1'b0;
      if (grant_n === 1'b0) go <= 1'b0;
      if (t[0] < 0 && req_n === 1'b0) t[0] = i;
      if (t[0] >= 0 && t[1] < 0 && bus_oe === 1'b0) t[1] = i;
      if (t[1] >= 0 && t[2] < 0 && grant_n === 1'b0) t[2] = i;
      if (t[2] >= 0 && t[3] < 0 && req_n === 1'b1) t[3] = i;
      if (t[3] >= 0 && t[4] < 0 && bus_oe === 1'b1) t[4] = i;
      if (t[4] >= 0 && t[5] < 0 && grant_n === 1'b1) t[5] = i;
      if (grant_n === 1'b0 && mclk !== last) tog++;
      if (grant_n === 1'b0 && mclk_oe === 1'b0) clkz = 1'b1;
      if (f && mclk_oe !== bus_oe) skew++;
      last = mclk;
    end
  endtask
  task automatic test_clock_sources();
    int e;
    for (int s = 0; s < 3; s++) begin
      sel <= 2'(s);
      e = (s == 0) ? 10 : (s == 1) ? 4 : 6;
      hold_cycle(1'b0, 1'b0);
      check(t[1] - t[0] >= 2 * e, 1);
      check(t[2] - t[1] <= 2 * e, 1);
      check(t[4] - t[3] >= 2 * e && t[4] - t[3] <= 7 * e, 1);
      check(t[5] >= 0 && t[5] - t[4] <= 2 * e, 1);
      check(tog > 1 && !clkz, 1);
      check(bus_q === bus_v, 1);
    end
  endtask
  task automatic test_float();
    hold_cycle(1'b1, 1'b0);
    check(clkz, 1);
    check(skew, 0);
  endtask
  task automatic test_refuse();
    int lows;
    lows = 0;
    refuse <= 1'b1;
    go <= 1'b1;
    repeat (120) begin
      @(posedge clk_i);
      if (grant_n !== 1'b1 || bus_oe !== 1'b1) lows++;
    end
    go <= 1'b0;
    repeat (20) @(posedge clk_i);
    refuse <= 1'b0;
    check(lows, 0);
  endtask
  task automatic test_pending();
    hold_cycle(1'b0, 1'b1);
    check(t[1] > 40 && t[5] >= 0, 1);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    test_clock_sources();
    test_float();
    test_refuse();
    test_pending();
    tally_and_finish();
  end
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
endmodule

// >>> hw/ebhh_defines.svh
// Timing counts and bus widths for the external bus hold handshake.
`ifndef EBHH_DEFINES_SVH
`define EBHH_DEFINES_SVH
`define EBHH_FLOAT_MIN_E 4'h2
`define EBHH_GRANT_MAX_E 4'h2
`define EBHH_DRIVE_MIN_E 4'h2
`define EBHH_DRIVE_MAX_E 4'h7
`define EBHH_DATA_W 32
`define EBHH_ADDR_W 20
`define EBHH_CE_W 4
`define EBHH_BE_W 4
`define EBHH_DIV4 2'h1
`define EBHH_DIV6 2'h2
`define EBHH_DIV4_LAST 3'h3
`define EBHH_DIV6_LAST 3'h5
`endif

// >>> hw/ebhh_hold.sv
// Hold handshake that hands the external memory bus to an outside master.
// What this block does
// - Pending memory transactions complete before grant is asserted.
// - Refusal bit set before the bus floats keeps the bus from being granted; once floated, grant still follows.
// - Float select zero keeps the memory clock toggling during hold.
// - Float select one puts the memory clock into high impedance during hold.
// - Bus floats no earlier than two interface periods after request falls.
// - Grant goes low zero to two periods after the bus floats.
// - Bus is driven again two to seven periods after request rises.
// - Grant returns high zero to two periods after bus is driven.
// - Floating clock follows the same float and resume timing as the bus.
// - Floated group covers enables, data, address, strobes, clock enable, output enable, transfer strobe.
// - Delays count periods of the selected interface clock.
`timescale 1ns/1ns
`include "ebhh_defines.svh"
module ebhh_hold (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Interface clock select: 0 external input clock, 1 CPU/4, 2 CPU/6
  input wire logic [1:0] clk_sel_i,
  input wire logic mem_clock_in_i,
  // Configuration
  input wire logic bus_release_refuse_i,
  input wire logic memclk_float_sel_i,
  // Memory interface side
  input wire logic xfer_pending_i,
  input wire ebhh_pkg::ebhh_bus_t bus_i,
  // Hold handshake pins, active low
  input wire logic ext_bus_req_n_i,
  output logic ext_bus_grant_n_o,
  // Memory bus pins
  output ebhh_pkg::ebhh_bus_t bus_o,
  output logic bus_oe_o,
  output logic mem_clock_out_o,
  output logic mem_clock_out_oe_o,
  // Status
  output logic hold_active_o
);
  ebhh_pkg::ebhh_state_t state_q;
  logic req_meta_q, req_sync_q;
  logic [2:0] div_q;
  logic tick;
  logic in_prev_q;
  logic memclk_q;
  logic [3:0] cnt_q;
  logic grant_n_q;
  logic bus_oe_q;
  logic clk_oe_q;
  ebhh_pkg::ebhh_bus_t bus_q;
  // Tick counters that only feed the timing assertions.
  logic [3:0] mon_req_ticks_q;
  logic [3:0] mon_float_ticks_q;
  logic [3:0] mon_wake_ticks_q;
  logic [3:0] mon_drive_ticks_q;

  function automatic logic [2:0] div_last(input logic [1:0] sel);
    if (sel == `EBHH_DIV4) begin
      div_last = `EBHH_DIV4_LAST;
    end else if (sel == `EBHH_DIV6) begin
      div_last = `EBHH_DIV6_LAST;
    end else begin
      div_last = 3'h0;
    end
  endfunction

  // Saturating step shared by the tick counters of the timing monitors.
  // Saturation keeps a long refusal or a long pending transfer from wrapping to a small value.
  function automatic logic [3:0] sat_inc(input logic [3:0] val);
    if (val == 4'hf) begin
      sat_inc = val;
    end else begin
      sat_inc = val + 4'h1;
    end
  endfunction

  // Request synchroniser; only the second stage is used.
  // The request comes from another master and has no fixed phase to this clock.
  // Both stages reset to the released level so that no false request follows reset.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      req_meta_q <= 1'b1;
      req_sync_q <= 1'b1;
    end else begin
      req_meta_q <= ext_bus_req_n_i;
      req_sync_q <= req_meta_q;
    end
  end

  // Interface clock tick: rising edge of the external clock or the divider wrap.
  // Every handshake delay is counted in these ticks, so all limits scale with the source.
  // The external clock must run slower than half the system clock to be seen.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div_q <= 3'h0;
      in_prev_q <= 1'b0;
      memclk_q <= 1'b0;
    end else begin
      in_prev_q <= mem_clock_in_i;
      div_q <= (div_q >= div_last(clk_sel_i)) ? 3'h0 : div_q + 3'h1;
      if (tick) begin
        memclk_q <= ~memclk_q;
      end
    end
  end

  assign tick = (clk_sel_i == 2'h0) ? (mem_clock_in_i & ~in_prev_q) : (div_q == 3'h0);

  // Handshake state machine; cnt_q counts interface periods.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q <= ebhh_pkg::EBHH_OWN;
      cnt_q <= 4'h0;
      grant_n_q <= 1'b1;
      bus_oe_q <= 1'b1;
      clk_oe_q <= 1'b1;
    end else begin
      case (state_q)
        // The device owns the bus and waits for an accepted request.
        ebhh_pkg::EBHH_OWN: begin
          cnt_q <= 4'h0;
          if (!req_sync_q && !bus_release_refuse_i) begin
            state_q <= ebhh_pkg::EBHH_DRAIN;
          end
        end
        // Minimum delay passes and pending transfers finish before the bus floats.
        ebhh_pkg::EBHH_DRAIN: begin
          if (req_sync_q) begin
            state_q <= ebhh_pkg::EBHH_OWN;
          end else if (tick) begin
            if (cnt_q < `EBHH_FLOAT_MIN_E) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (!xfer_pending_i && !bus_release_refuse_i) begin
              bus_oe_q <= 1'b0;
              clk_oe_q <= !memclk_float_sel_i;
              cnt_q <= 4'h0;
              state_q <= ebhh_pkg::EBHH_FLOAT;
            end
          end
        end
        // The bus is floated; grant follows on the next tick.
        ebhh_pkg::EBHH_FLOAT: begin
          if (tick) begin
            grant_n_q <= 1'b0;
            state_q <= ebhh_pkg::EBHH_HELD;
          end
        end
        // The outside master owns the bus until it releases its request.
        ebhh_pkg::EBHH_HELD: begin
          cnt_q <= 4'h0;
          if (req_sync_q) begin
            state_q <= ebhh_pkg::EBHH_WAKE;
          end
        end
        // The outside master may still be turning its drivers off, so wait before driving.
        ebhh_pkg::EBHH_WAKE: begin
          if (tick) begin
            if (cnt_q < `EBHH_DRIVE_MIN_E) begin
              cnt_q <= cnt_q + 4'h1;
            end else begin
              bus_oe_q <= 1'b1;
              clk_oe_q <= 1'b1;
              state_q <= ebhh_pkg::EBHH_DRIVE;
            end
          end
        end
        // The bus is driven again; grant is withdrawn on the next tick.
        ebhh_pkg::EBHH_DRIVE: begin
          if (tick) begin
            grant_n_q <= 1'b1;
            state_q <= ebhh_pkg::EBHH_OWN;
          end
        end
        default: begin
          state_q <= ebhh_pkg::EBHH_OWN;
        end
      endcase
    end
  end

  // Registered copy of the memory bus values.
  // The values keep flowing during hold; only the enable decides who drives the pins.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bus_q <= '0;
    end else begin
      bus_q <= bus_i;
    end
  end

  assign bus_o = bus_q;
  assign bus_oe_o = bus_oe_q;
  assign mem_clock_out_o = memclk_q;
  assign mem_clock_out_oe_o = clk_oe_q;
  assign ext_bus_grant_n_o = grant_n_q;
  assign hold_active_o = !grant_n_q;

  // Timing monitors. Each counter counts interface ticks inside one phase of the
  // handshake and clears outside it, so the assertions below can bound each delay
  // in interface periods rather than in system clocks.

  // Ticks since the synchronised request fell, while the bus is still driven.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mon_req_ticks_q <= 4'h0;
    end else if (req_sync_q || !bus_oe_q) begin
      mon_req_ticks_q <= 4'h0;
    end else if (tick) begin
      mon_req_ticks_q <= sat_inc(mon_req_ticks_q);
    end
  end

  // Ticks since the bus floated, while grant is still high.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mon_float_ticks_q <= 4'h0;
    end else if (bus_oe_q || !grant_n_q) begin
      mon_float_ticks_q <= 4'h0;
    end else if (tick) begin
      mon_float_ticks_q <= sat_inc(mon_float_ticks_q);
    end
  end

  // Ticks since the synchronised request rose, while the bus is still floated.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mon_wake_ticks_q <= 4'h0;
    end else if (!req_sync_q || bus_oe_q) begin
      mon_wake_ticks_q <= 4'h0;
    end else if (tick) begin
      mon_wake_ticks_q <= sat_inc(mon_wake_ticks_q);
    end
  end

  // Ticks since the bus is driven again, while grant is still low.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mon_drive_ticks_q <= 4'h0;
    end else if (!bus_oe_q || grant_n_q) begin
      mon_drive_ticks_q <= 4'h0;
    end else if (tick) begin
      mon_drive_ticks_q <= sat_inc(mon_drive_ticks_q);
    end
  end

  // Grant may only fall once the bus is floated; it may stay low briefly after the bus is driven.
  a_grant_needs_float: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(ext_bus_grant_n_o) |-> !bus_oe_o) else $error("grant low while bus driven");
  a_float_min_ticks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(bus_oe_o) |-> mon_req_ticks_q >= (`EBHH_FLOAT_MIN_E + 4'h1)) else $error("float too soon");
  a_grant_fall_ticks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mon_float_ticks_q <= `EBHH_GRANT_MAX_E) else $error("grant late after float");
  a_drive_window_lo: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(bus_oe_o) |-> mon_wake_ticks_q >= (`EBHH_DRIVE_MIN_E + 4'h1)) else $error("bus driven too soon");
  a_drive_window_hi: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mon_wake_ticks_q <= `EBHH_DRIVE_MAX_E) else $error("bus driven too late");
  a_grant_rise_ticks: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mon_drive_ticks_q <= `EBHH_GRANT_MAX_E) else $error("grant late after drive");
  a_memclk_running: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tick |=> $changed(mem_clock_out_o)) else $error("memory clock stopped");
  a_refused_stays_owned: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (bus_release_refuse_i && bus_oe_o && ext_bus_grant_n_o) |=> bus_oe_o) else $error("float despite refusal");
  a_held_bus_floated: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_q == ebhh_pkg::EBHH_HELD) |-> !bus_oe_o) else $error("bus driven during hold");
  a_clock_oe_follows: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !mem_clock_out_oe_o |-> !bus_oe_o) else $error("clock floated with bus driven");
  a_drain_waits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_q == ebhh_pkg::EBHH_DRAIN && xfer_pending_i) |=> bus_oe_o) else $error("float during transfer");
  a_refuse_blocks_grant: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (bus_release_refuse_i && ext_bus_grant_n_o) |=> ext_bus_grant_n_o) else $error("grant despite refusal");
  a_no_float_pending: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(bus_oe_o) |-> !$past(xfer_pending_i)) else $error("floated with pending transfer");
  a_float_not_early: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(req_sync_q) |-> bus_oe_o [*2]) else $error("bus floated too early");
  a_clock_keeps: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($fell(bus_oe_o) && !$past(memclk_float_sel_i)) |-> mem_clock_out_oe_o) else $error("clock floated");
  a_clock_floats: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($fell(bus_oe_o) && $past(memclk_float_sel_i)) |-> !mem_clock_out_oe_o) else $error("clock driven");
  a_clock_with_bus: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(bus_oe_o) |-> mem_clock_out_oe_o) else $error("clock not resumed with bus");
  a_grant_rise_after: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(ext_bus_grant_n_o) |-> bus_oe_o) else $error("grant released before bus driven");
  a_drive_after_req: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(bus_oe_o) |-> req_sync_q) else $error("bus driven while request low");
  a_sync_two_stage: assert property (@(posedge clk_i) disable iff (!nrst_i)
    req_sync_q == $past(ext_bus_req_n_i, 2) || !$past(nrst_i)) else $error("synchroniser depth");

  c_hold_granted: cover property (@(posedge clk_i) disable iff (!nrst_i) $fell(ext_bus_grant_n_o));
  c_hold_released: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(ext_bus_grant_n_o));
  c_clock_floated: cover property (@(posedge clk_i) disable iff (!nrst_i) !mem_clock_out_oe_o);
  c_request_refused: cover property (@(posedge clk_i) disable iff (!nrst_i) bus_release_refuse_i && !req_sync_q);
  c_pending_wait: cover property (@(posedge clk_i) disable iff (!nrst_i)
    state_q == ebhh_pkg::EBHH_DRAIN && xfer_pending_i);
endmodule

// >>> hw/ebhh_pkg.sv
// Types for the external bus hold handshake.
package ebhh_pkg;
  typedef enum logic [2:0] {
    EBHH_OWN   = 3'b000,
    EBHH_DRAIN = 3'b001,
    EBHH_FLOAT = 3'b011,
    EBHH_HELD  = 3'b010,
    EBHH_WAKE  = 3'b110,
    EBHH_DRIVE = 3'b111
  } ebhh_state_t;
  typedef struct packed {
    logic [3:0] chip_en;
    logic [3:0] byte_enable_lines;
    logic [31:0] memory_data_lines;
    logic [19:0] memory_address_lines;
    logic [2:0] strobes;
    logic sdram_clock_enable;
    logic third_output_enable;
    logic peripheral_transfer_strobe;
  } ebhh_bus_t;
endpackage
